// [hw/charger_status_registers.sv]
// charger status register group behind a two-wire serial slave port.
// assumes scl and sda are pins from the host, with the sda wire resolved
// outside from sdaOut and sdaOe; status inputs come from sys_clk logic.
//
// Operation
// - charge phase field, codes zero to four
// - phase reads six top-off, seven terminated
// - input source codes one to six
// - source zero: no input or boost limit
// - source seven, eight, B, C; others reserved
// - detection-complete bit set after port detection
// - optimizer state: disabled, running, found
// - thermal regulation bit follows die regulation
// - detection-active bit only while detection runs
// - battery present above undervoltage release level
// - two bits report input switch pairs populated
// - conversion-done bit, meaningful in one-shot mode
// - forward mode: battery below minimum system voltage
// - fast-charge safety timer expired bit
// - trickle-charge safety timer expired bit
module charger_status_registers #(
  parameter logic [6:0] SLAVE_ADDR = charger_status_pkg::SLAVE_ADDR_DEFAULT
) (
  // clock, reset and serial pins
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,

  // charge phase engine
  input wire logic chargeEnabled,
  input wire logic inTrickle,
  input wire logic inPrecharge,
  input wire logic inFastCc,
  input wire logic inTaperCv,
  input wire logic topOffRunning,
  input wire logic chargeTerminated,

  // input source detection
  input wire logic inputPresent,
  input wire logic reverseBoost,
  input wire logic boostHotLimit,
  input wire logic boostColdLimit,
  input wire logic backupMode,
  input wire logic directFromBus,
  input wire logic unqualifiedAdapter,
  input wire logic [2:0] portKind,
  input wire logic portDetectComplete,

  // second status byte
  input wire logic optimizerEnabled,
  input wire logic optimizerFound,
  input wire logic dieThermalReg,
  input wire logic portDetectActive,
  input wire logic batAboveUvRelease,

  // third status byte
  input wire logic inputPairTwoPopulated,
  input wire logic inputPairOnePopulated,
  input wire logic adcOneShotMode,
  input wire logic adcConversionDone,
  input wire logic forwardMode,
  input wire logic batBelowMinSystem,
  input wire logic fastTimerExpired,
  input wire logic trickleTimerExpired
);
  import charger_status_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    slave_state_e state;
    logic [2:0] bitCount;
    logic byteFull;
    logic [7:0] shift;
    logic [7:0] pointer;
    logic readMode;

    logic sclPrev;
    logic sdaPrev;

    logic sdaOe;
    logic sdaOut;
  } slave_s;

  slave_s cur;
  slave_s next_cur;

  logic [1:0] pinLevel;
  logic sclLevel;
  logic sdaLevel;

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  logic [7:0] statusOne;
  logic [7:0] statusTwo;
  logic [7:0] statusThree;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pin_sync #(
    .WIDTH(2),
    .IDLE_LEVEL(2'h3)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn({scl, sdaIn}),
    .pinLevel(pinLevel)
  );

  assign sclLevel = pinLevel[1];
  assign sdaLevel = pinLevel[0];

  // ****************************************************************
  // status sampling
  // ****************************************************************
  status_encoder u_status_encoder (
    .sys_clk(sys_clk),
    .rst(rst),

    .chargeEnabled(chargeEnabled),
    .inTrickle(inTrickle),
    .inPrecharge(inPrecharge),
    .inFastCc(inFastCc),
    .inTaperCv(inTaperCv),
    .topOffRunning(topOffRunning),
    .chargeTerminated(chargeTerminated),

    .inputPresent(inputPresent),
    .reverseBoost(reverseBoost),
    .boostHotLimit(boostHotLimit),
    .boostColdLimit(boostColdLimit),
    .backupMode(backupMode),
    .directFromBus(directFromBus),
    .unqualifiedAdapter(unqualifiedAdapter),
    .portKind(portKind),
    .portDetectComplete(portDetectComplete),

    .optimizerEnabled(optimizerEnabled),
    .optimizerFound(optimizerFound),
    .dieThermalReg(dieThermalReg),
    .portDetectActive(portDetectActive),
    .batAboveUvRelease(batAboveUvRelease),

    .inputPairTwoPopulated(inputPairTwoPopulated),
    .inputPairOnePopulated(inputPairOnePopulated),
    .adcOneShotMode(adcOneShotMode),
    .adcConversionDone(adcConversionDone),
    .forwardMode(forwardMode),
    .batBelowMinSystem(batBelowMinSystem),
    .fastTimerExpired(fastTimerExpired),
    .trickleTimerExpired(trickleTimerExpired),
    .statusOne(statusOne),
    .statusTwo(statusTwo),
    .statusThree(statusThree)
  );

  // ****************************************************************
  // register read decode
  // ****************************************************************
  // unmapped offsets read as zero
  function automatic logic [7:0] readByte(input logic [7:0] offset);
    if (offset == STATUS_ONE_ADDR) begin
      return statusOne;
    end else if (offset == STATUS_TWO_ADDR) begin
      return statusTwo;
    end else if (offset == STATUS_THREE_ADDR) begin
      return statusThree;
    end
    return UNMAPPED_READ;
  endfunction

  // pointer steps with an 8-bit wrap
  function automatic logic [7:0] nextPointer(input logic [7:0] p);
    return p + 8'h01;
  endfunction

  // fetches a read byte and presents its msb
  function automatic slave_s loadRead(input slave_s s, input logic [7:0] offset);
    slave_s n;
    n = s;
    n.shift = readByte(offset);
    n.sdaOe = !n.shift[7];
    n.bitCount = 3'h0;
    n.state = SL_READ;
    return n;
  endfunction

  // ****************************************************************
  // bus conditions
  // ****************************************************************
  // filtered levels lag the pins by four clocks
  assign sclRise = sclLevel && !cur.sclPrev;
  assign sclFall = !sclLevel && cur.sclPrev;

  assign startSeen = sclLevel && cur.sclPrev && cur.sdaPrev && !sdaLevel;
  assign stopSeen = sclLevel && cur.sclPrev && !cur.sdaPrev && sdaLevel;

  // ****************************************************************
  // serial slave
  // ****************************************************************
  always_comb begin
    next_cur = cur;
    next_cur.sclPrev = sclLevel;
    next_cur.sdaPrev = sdaLevel;
    // open drain: only ever pulls low
    next_cur.sdaOut = 1'b0;

    if (startSeen) begin
      // start or repeated start re-arms address reception
      next_cur.state = SL_ADDR;
      next_cur.bitCount = 3'h0;
      next_cur.byteFull = 1'b0;
      next_cur.sdaOe = 1'b0;
    end else if (stopSeen) begin
      next_cur.state = SL_IDLE;
      next_cur.sdaOe = 1'b0;
    end else begin
      case (cur.state)
        SL_IDLE: begin
          next_cur.sdaOe = 1'b0;
        end

        SL_ADDR, SL_POINTER, SL_WRITE: begin
          if (sclRise) begin
            next_cur.shift = {cur.shift[6:0], sdaLevel};
            next_cur.bitCount = cur.bitCount + 3'h1;
            next_cur.byteFull = (cur.bitCount == 3'h7);
          end else if (sclFall && cur.byteFull) begin
            next_cur.byteFull = 1'b0;
            if (cur.state == SL_ADDR) begin
              if (cur.shift[7:1] == SLAVE_ADDR) begin
                next_cur.readMode = cur.shift[0];
                next_cur.sdaOe = 1'b1;
                next_cur.state = SL_ADDR_ACK;
              end else begin
                next_cur.state = SL_IDLE;
              end
            end else if (cur.state == SL_POINTER) begin
              next_cur.pointer = cur.shift;
              next_cur.sdaOe = 1'b1;
              next_cur.state = SL_POINTER_ACK;
            end else begin
              // data byte acknowledged and dropped
              next_cur.pointer = nextPointer(cur.pointer);
              next_cur.sdaOe = 1'b1;
              next_cur.state = SL_WRITE_ACK;
            end
          end
        end

        SL_ADDR_ACK: begin
          if (sclFall) begin
            next_cur.bitCount = 3'h0;
            if (cur.readMode) begin
              next_cur = loadRead(next_cur, cur.pointer);
            end else begin
              next_cur.sdaOe = 1'b0;
              next_cur.state = SL_POINTER;
            end
          end
        end

        SL_POINTER_ACK, SL_WRITE_ACK: begin
          if (sclFall) begin
            next_cur.sdaOe = 1'b0;
            next_cur.bitCount = 3'h0;
            next_cur.state = SL_WRITE;
          end
        end

        SL_READ: begin
          if (sclFall) begin
            if (cur.bitCount == 3'h7) begin
              // free the wire for the host's acknowledge
              next_cur.sdaOe = 1'b0;
              next_cur.byteFull = 1'b0;
              next_cur.state = SL_READ_ACK;
            end else begin
              next_cur.shift = {cur.shift[6:0], 1'b0};
              next_cur.sdaOe = !cur.shift[6];
              next_cur.bitCount = cur.bitCount + 3'h1;
            end
          end
        end

        SL_READ_ACK: begin
          if (sclRise) begin
            if (sdaLevel) begin
              // host ends the read with a not-acknowledge
              next_cur.state = SL_IDLE;
            end else begin
              next_cur.byteFull = 1'b1;
            end
          end else if (sclFall && cur.byteFull) begin
            next_cur.byteFull = 1'b0;
            next_cur.pointer = nextPointer(cur.pointer);
            next_cur = loadRead(next_cur, nextPointer(cur.pointer));
          end
        end

        default: begin
          next_cur.state = SL_IDLE;
          next_cur.sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur.state <= SL_IDLE;
      cur.bitCount <= 3'h0;
      cur.byteFull <= 1'b0;
      cur.shift <= 8'h00;
      cur.pointer <= 8'h00;
      cur.readMode <= 1'b0;
      // idle-high history, so reset brings no false edge
      cur.sclPrev <= 1'b1;
      cur.sdaPrev <= 1'b1;
      cur.sdaOe <= 1'b0;
      cur.sdaOut <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign sdaOut = cur.sdaOut;
  assign sdaOe = cur.sdaOe;

endmodule

// [hw/charger_status_pkg.sv]
// package of the charger status register group: offsets, field positions,
// reset values, status codes and serial slave states.
// assumes nothing beyond a SystemVerilog compiler.
package charger_status_pkg;

  // ****************************************************************
  // register offsets and reset values
  // ****************************************************************
  localparam logic [7:0] STATUS_ONE_ADDR = 8'h1C;
  localparam logic [7:0] STATUS_TWO_ADDR = 8'h1D;
  localparam logic [7:0] STATUS_THREE_ADDR = 8'h1E;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // default 7-bit slave address, value is arbitrary
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PHASE_LSB = 5;
  localparam int SOURCE_LSB = 1;
  localparam int DETECT_DONE_BIT = 0;
  localparam int OPTIMIZER_LSB = 6;
  localparam int THERMAL_BIT = 2;
  localparam int DETECT_ACTIVE_BIT = 1;
  localparam int BAT_PRESENT_BIT = 0;
  localparam int PAIR_TWO_BIT = 7;
  localparam int PAIR_ONE_BIT = 6;
  localparam int ADC_DONE_BIT = 5;
  localparam int SYS_REG_BIT = 4;
  localparam int FAST_TIMER_BIT = 3;
  localparam int TRICKLE_TIMER_BIT = 2;

  // ****************************************************************
  // status codes
  // ****************************************************************
  typedef enum logic [2:0] {
    PHASE_IDLE = 3'h0,
    PHASE_TRICKLE = 3'h1,
    PHASE_PRECHARGE = 3'h2,
    PHASE_FAST_CC = 3'h3,
    PHASE_TAPER_CV = 3'h4,
    PHASE_TOP_OFF = 3'h6,
    PHASE_DONE = 3'h7
  } charge_phase_e;

  typedef enum logic [3:0] {
    SRC_NONE = 4'h0,
    SRC_STANDARD = 4'h1,
    SRC_CHARGING_DS = 4'h2,
    SRC_DEDICATED = 4'h3,
    SRC_HIGH_VOLTAGE = 4'h4,
    SRC_UNKNOWN = 4'h5,
    SRC_NON_STANDARD = 4'h6,
    SRC_REVERSE_BOOST = 4'h7,
    SRC_UNQUALIFIED = 4'h8,
    SRC_DIRECT_BUS = 4'hB,
    SRC_BACKUP = 4'hC
  } input_source_e;

  typedef enum logic [1:0] {
    OPT_DISABLED = 2'h0,
    OPT_RUNNING = 2'h1,
    OPT_FOUND = 2'h2
  } optimizer_e;

  typedef enum logic [3:0] {
    SL_IDLE = 4'h0,
    SL_ADDR = 4'h1,
    SL_ADDR_ACK = 4'h2,
    SL_POINTER = 4'h3,
    SL_POINTER_ACK = 4'h4,
    SL_WRITE = 4'h5,
    SL_WRITE_ACK = 4'h6,
    SL_READ = 4'h7,
    SL_READ_ACK = 4'h8
  } slave_state_e;

endpackage

// [hw/pin_sync.sv]
// three-stage synchroniser with agreement filter for pin inputs.
// assumes the pins are asynchronous to sys_clk.
module pin_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinLevel
);

  typedef struct packed {
    logic [WIDTH-1:0] stageOne;
    logic [WIDTH-1:0] stageTwo;
    logic [WIDTH-1:0] stageThree;
    logic [WIDTH-1:0] level;
  } sync_s;

  sync_s cur;
  sync_s next_cur;

  // ****************************************************************
  // a change counts once stages two and three agree
  // ****************************************************************
  always_comb begin
    next_cur = cur;
    next_cur.stageOne = pinIn;
    next_cur.stageTwo = cur.stageOne;
    next_cur.stageThree = cur.stageTwo;
    for (int i = 0; i < WIDTH; i++) begin
      if (cur.stageTwo[i] == cur.stageThree[i]) begin
        next_cur.level[i] = cur.stageThree[i];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur <= {IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL};
    end else begin
      cur <= next_cur;
    end
  end

  assign pinLevel = cur.level;

endmodule

// [hw/status_encoder.sv]
// samples the charger engines' status and forms the three status bytes.
// assumes all status inputs come from logic on sys_clk.
module status_encoder (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic chargeEnabled,
  input wire logic inTrickle,
  input wire logic inPrecharge,
  input wire logic inFastCc,
  input wire logic inTaperCv,
  input wire logic topOffRunning,
  input wire logic chargeTerminated,
  input wire logic inputPresent,
  input wire logic reverseBoost,
  input wire logic boostHotLimit,
  input wire logic boostColdLimit,
  input wire logic backupMode,
  input wire logic directFromBus,
  input wire logic unqualifiedAdapter,
  input wire logic [2:0] portKind,
  input wire logic portDetectComplete,
  input wire logic optimizerEnabled,
  input wire logic optimizerFound,
  input wire logic dieThermalReg,
  input wire logic portDetectActive,
  input wire logic batAboveUvRelease,
  input wire logic inputPairTwoPopulated,
  input wire logic inputPairOnePopulated,
  input wire logic adcOneShotMode,
  input wire logic adcConversionDone,
  input wire logic forwardMode,
  input wire logic batBelowMinSystem,
  input wire logic fastTimerExpired,
  input wire logic trickleTimerExpired,
  output logic [7:0] statusOne,
  output logic [7:0] statusTwo,
  output logic [7:0] statusThree
);
  import charger_status_pkg::*;

  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
    logic [7:0] three;
  } status_s;

  status_s cur;
  status_s next_cur;

  // ****************************************************************
  // code selection
  // ****************************************************************
  function automatic charge_phase_e phaseCode(input logic [6:0] f);
    // f = {done, topOff, cv, cc, pre, trickle, enabled}
    if (f[6]) begin
      return PHASE_DONE;
    end else if (!f[0]) begin
      return PHASE_IDLE;
    end else if (f[5]) begin
      return PHASE_TOP_OFF;
    end else if (f[4]) begin
      return PHASE_TAPER_CV;
    end else if (f[3]) begin
      return PHASE_FAST_CC;
    end else if (f[2]) begin
      return PHASE_PRECHARGE;
    end else if (f[1]) begin
      return PHASE_TRICKLE;
    end
    return PHASE_IDLE;
  endfunction

  function automatic input_source_e sourceCode();
    if (reverseBoost) begin
      if (boostHotLimit || boostColdLimit) begin
        return SRC_NONE;
      end
      return SRC_REVERSE_BOOST;
    end else if (backupMode) begin
      return SRC_BACKUP;
    end else if (!inputPresent) begin
      return SRC_NONE;
    end else if (directFromBus) begin
      return SRC_DIRECT_BUS;
    end else if (unqualifiedAdapter) begin
      return SRC_UNQUALIFIED;
    end else if (portKind >= 3'h1 && portKind <= 3'h6) begin
      return input_source_e'({1'b0, portKind});
    end
    return SRC_NONE;
  endfunction

  // ****************************************************************
  // byte assembly, reserved bits stay zero
  // ****************************************************************
  always_comb begin
    next_cur = '{default: '0};
    next_cur.one[PHASE_LSB +: 3] = phaseCode({chargeTerminated, topOffRunning,
        inTaperCv, inFastCc, inPrecharge, inTrickle, chargeEnabled});
    next_cur.one[SOURCE_LSB +: 4] = sourceCode();
    next_cur.one[DETECT_DONE_BIT] = portDetectComplete;
    if (optimizerEnabled) begin
      next_cur.two[OPTIMIZER_LSB +: 2] = optimizerFound ? OPT_FOUND : OPT_RUNNING;
    end
    next_cur.two[THERMAL_BIT] = dieThermalReg;
    next_cur.two[DETECT_ACTIVE_BIT] = portDetectActive;
    next_cur.two[BAT_PRESENT_BIT] = batAboveUvRelease;
    next_cur.three[PAIR_TWO_BIT] = inputPairTwoPopulated;
    next_cur.three[PAIR_ONE_BIT] = inputPairOnePopulated;
    next_cur.three[ADC_DONE_BIT] = adcOneShotMode && adcConversionDone;
    next_cur.three[SYS_REG_BIT] = forwardMode && batBelowMinSystem;
    next_cur.three[FAST_TIMER_BIT] = fastTimerExpired;
    next_cur.three[TRICKLE_TIMER_BIT] = trickleTimerExpired;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur <= {STATUS_RESET, STATUS_RESET, STATUS_RESET};
    end else begin
      cur <= next_cur;
    end
  end

  assign statusOne = cur.one;
  assign statusTwo = cur.two;
  assign statusThree = cur.three;

endmodule

// [tb/charger_status_registers_props.sv]
// checker on the serial pins of the charger status register group.
// assumes it is bound to charger_status_registers and sees only its ports.
module charger_status_registers_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // pin behaviour
  // ****************************************************************
  chk_drive_low_only: assert property (
    @(posedge sys_clk) disable iff (rst) !sdaOut)
    else $error("sda drive value is not low");
  chk_idle_in_reset: assert property (
    @(posedge sys_clk) rst |-> !sdaOe)
    else $error("sda driven during reset");
  chk_release_quiet: assert property (
    @(posedge sys_clk) disable iff (rst) $fell(rst) |-> !sdaOe ##1 !sdaOe)
    else $error("sda driven right after reset release");
  chk_oe_quiet_high: assert property (
    @(posedge sys_clk) disable iff (rst) scl && $past(scl, 6) |-> $stable(sdaOe))
    else $error("sda drive changed while scl high");
  chk_oe_after_fall: assert property (
    @(posedge sys_clk) disable iff (rst) $changed(sdaOe) |-> !scl)
    else $error("sda drive changed outside scl low phase");
  chk_oe_sync_lag: assert property (
    @(posedge sys_clk) disable iff (rst) $fell(scl) |=> $stable(sdaOe) ##1 $stable(sdaOe))
    else $error("sda drive reacted faster than the pin sync");
  chk_start_free: assert property (
    @(posedge sys_clk) disable iff (rst) scl && $fell(sdaIn) |-> !sdaOe [*8])
    else $error("sda driven around a start condition");
  chk_stop_free: assert property (
    @(posedge sys_clk) disable iff (rst) scl && $rose(sdaIn) |-> !sdaOe && !$past(sdaOe))
    else $error("sda driven around a stop condition");
endmodule

bind charger_status_registers charger_status_registers_props i_charger_status_registers_props (
  .sys_clk(sys_clk), .rst(rst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));

// [tb/test_charger_status_registers.sv]
// self-checking bench of the charger status register group.
// assumes the design's default slave address; the bench acts as serial host.
module test_charger_status_registers;
  import charger_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk;
  logic rst;
  logic scl;
  logic hostSda;
  logic sdaWire;
  logic sdaOut;
  logic sdaOe;
  logic [27:0] st;
  logic [2:0] kind;
  logic [7:0] rd [4];
  int n_errors = 0;
  int compares = 0;

  // open-drain wire with pull-up: low if either party pulls
  assign sdaWire = hostSda & ~(sdaOe & ~sdaOut);

  charger_status_registers i_charger_status_registers (
    .sys_clk(sys_clk), .rst(rst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .chargeEnabled(st[0]), .inTrickle(st[1]), .inPrecharge(st[2]), .inFastCc(st[3]),
    .inTaperCv(st[4]), .topOffRunning(st[5]), .chargeTerminated(st[6]),
    .inputPresent(st[7]), .reverseBoost(st[8]), .boostHotLimit(st[9]),
    .boostColdLimit(st[10]), .backupMode(st[11]), .directFromBus(st[12]),
    .unqualifiedAdapter(st[13]), .portKind(kind), .portDetectComplete(st[14]),
    .optimizerEnabled(st[15]), .optimizerFound(st[16]), .dieThermalReg(st[17]),
    .portDetectActive(st[18]), .batAboveUvRelease(st[19]), .inputPairTwoPopulated(st[20]),
    .inputPairOnePopulated(st[21]), .adcOneShotMode(st[22]), .adcConversionDone(st[23]),
    .forwardMode(st[24]), .batBelowMinSystem(st[25]), .fastTimerExpired(st[26]),
    .trickleTimerExpired(st[27]));

  // ****************************************************************
  // host helpers
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one scl period: data set mid low phase, wire sampled mid high phase
  task automatic clockBit(input logic b, output logic seen);
    scl <= 1'b0;
    tick(5);
    hostSda <= b;
    tick(5);
    scl <= 1'b1;
    tick(5);
    seen = sdaWire;
    tick(5);
  endtask

  task automatic xferByte(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
      output logic ackSeen);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      clockBit(tx[i], rx[i]);
    end
    clockBit(ackIn, a);
    ackSeen = !a;
  endtask

  // also serves as repeated start
  task automatic startCond();
    scl <= 1'b0;
    tick(5);
    hostSda <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(10);
    hostSda <= 1'b0;
    tick(10);
  endtask

  task automatic stopCond();
    scl <= 1'b0;
    tick(5);
    hostSda <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(10);
    hostSda <= 1'b1;
    tick(10);
  endtask

  // pointer write, repeated start, n bytes read, last one not acknowledged
  task automatic readAt(input logic [7:0] addr, input int n);
    logic [7:0] rx;
    logic ack;
    startCond();
    xferByte({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, rx, ack);
    xferByte(addr, 1'b1, rx, ack);
    startCond();
    xferByte({SLAVE_ADDR_DEFAULT, 1'b1}, 1'b1, rx, ack);
    for (int i = 0; i < n; i++) begin
      xferByte(8'hFF, 1'(i == n - 1), rd[i], ack);
    end
    stopCond();
  endtask

  task automatic probe(input logic [27:0] s, input logic [2:0] k, input logic [7:0] addr,
      input logic [7:0] mask, input logic [7:0] exp);
    st <= s;
    kind <= k;
    tick(3);
    readAt(addr, 1);
    check($sformatf("register %h field", addr), rd[0] & mask, exp);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic resetValues();
    readAt(STATUS_ONE_ADDR, 4);
    check("status one reset", rd[0], STATUS_RESET);
    check("status two reset", rd[1], STATUS_RESET);
    check("status three reset", rd[2], STATUS_RESET);
    check("unmapped read", rd[3], UNMAPPED_READ);
  endtask

  task automatic phaseCodes();
    probe(28'h0000002, 3'h0, STATUS_ONE_ADDR, 8'hE0, 8'h00);
    probe(28'h0000003, 3'h0, STATUS_ONE_ADDR, 8'hE0, 8'h20);
    probe(28'h0000005, 3'h0, STATUS_ONE_ADDR, 8'hE0, 8'h40);
    probe(28'h0000009, 3'h0, STATUS_ONE_ADDR, 8'hE0, 8'h60);
    probe(28'h0000011, 3'h0, STATUS_ONE_ADDR, 8'hE0, 8'h80);
    probe(28'h0000031, 3'h0, STATUS_ONE_ADDR, 8'hE0, 8'hC0);
    probe(28'h0000040, 3'h0, STATUS_ONE_ADDR, 8'hE0, 8'hE0);
  endtask

  task automatic sourceCodes();
    for (int k = 1; k <= 6; k++) begin
      probe(28'h0000080, 3'(k), STATUS_ONE_ADDR, 8'h1E, 8'(k << 1));
    end
    probe(28'h0000080, 3'h7, STATUS_ONE_ADDR, 8'h1E, 8'h00);
    probe(28'h0000000, 3'h1, STATUS_ONE_ADDR, 8'h1E, 8'h00);
    probe(28'h0000380, 3'h1, STATUS_ONE_ADDR, 8'h1E, 8'h00);
    probe(28'h0000580, 3'h1, STATUS_ONE_ADDR, 8'h1E, 8'h00);
    probe(28'h0000180, 3'h1, STATUS_ONE_ADDR, 8'h1E, 8'h0E);
    probe(28'h0002080, 3'h1, STATUS_ONE_ADDR, 8'h1E, 8'h10);
    probe(28'h0001080, 3'h1, STATUS_ONE_ADDR, 8'h1E, 8'h16);
    probe(28'h0000800, 3'h1, STATUS_ONE_ADDR, 8'h1E, 8'h18);
    probe(28'h0000000, 3'h0, STATUS_ONE_ADDR, 8'h01, 8'h00);
    probe(28'h0004000, 3'h0, STATUS_ONE_ADDR, 8'h01, 8'h01);
  endtask

  task automatic statusTwoBits();
    probe(28'h0008000, 3'h0, STATUS_TWO_ADDR, 8'hFF, 8'h40);
    probe(28'h0018000, 3'h0, STATUS_TWO_ADDR, 8'hFF, 8'h80);
    probe(28'h0020000, 3'h0, STATUS_TWO_ADDR, 8'hFF, 8'h04);
    probe(28'h0040000, 3'h0, STATUS_TWO_ADDR, 8'hFF, 8'h02);
    probe(28'h0080000, 3'h0, STATUS_TWO_ADDR, 8'hFF, 8'h01);
    probe(28'hFFFFFFF, 3'h0, STATUS_TWO_ADDR, 8'hFF, 8'h87);
  endtask

  task automatic statusThreeBits();
    probe(28'h0100000, 3'h0, STATUS_THREE_ADDR, 8'hFF, 8'h80);
    probe(28'h0200000, 3'h0, STATUS_THREE_ADDR, 8'hFF, 8'h40);
    probe(28'h0C00000, 3'h0, STATUS_THREE_ADDR, 8'hFF, 8'h20);
    probe(28'h0800000, 3'h0, STATUS_THREE_ADDR, 8'hFF, 8'h00);
    probe(28'h3000000, 3'h0, STATUS_THREE_ADDR, 8'hFF, 8'h10);
    probe(28'h2000000, 3'h0, STATUS_THREE_ADDR, 8'hFF, 8'h00);
    probe(28'h4000000, 3'h0, STATUS_THREE_ADDR, 8'hFF, 8'h08);
    probe(28'h8000000, 3'h0, STATUS_THREE_ADDR, 8'hFF, 8'h04);
  endtask

  task automatic writesIgnored();
    logic [7:0] rx;
    logic ack;
    st <= 28'hFFFFFFF;
    kind <= 3'h1;
    tick(3);
    startCond();
    xferByte({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, rx, ack);
    xferByte(STATUS_THREE_ADDR, 1'b1, rx, ack);
    xferByte(8'h00, 1'b1, rx, ack);
    stopCond();
    readAt(STATUS_THREE_ADDR, 1);
    check("status three after write", rd[0], 8'hFC);
    startCond();
    xferByte({SLAVE_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b1, rx, ack);
    check("foreign address ack", {7'h00, ack}, 8'h00);
    stopCond();
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    tick(90000);
    n_errors++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    scl = 1'b1;
    hostSda = 1'b1;
    st = '0;
    kind = 3'h0;
    tick(8);
    rst <= 1'b0;
    tick(6);
    resetValues();
    phaseCodes();
    sourceCodes();
    statusTwoBits();
    statusThreeBits();
    writesIgnored();
    final_report();
  end
endmodule
